// [adc_conv_clk_gen.sv]
`timescale 1ns/1ps
module adc_conv_clk_gen
  import adc_regs_pkg::*;
#(
  parameter int unsigned FAST_HALF = FAST_HALF_CYC,
  parameter int unsigned SLOW_HALF = SLOW_HALF_CYC
) (
  input  wire logic i_clk_sys,
  input  wire logic i_nrst,
  input  wire logic i_en,
  input  wire logic i_fast,
  output logic      o_conv_clk
);
  import adc_regs_pkg::*;

  localparam logic [DIV_W-1:0] FAST_LAST = DIV_W'(FAST_HALF - 1);
  localparam logic [DIV_W-1:0] SLOW_LAST = DIV_W'(SLOW_HALF - 1);

  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] last;

  assign last = i_fast ? FAST_LAST : SLOW_LAST;

  // Divider; a rate switch may cut the running half period short
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q      <= '0;
      o_conv_clk <= 1'b0;
    end else if (i_en) begin
      if (cnt_q >= last) begin
        cnt_q      <= '0;
        o_conv_clk <= ~o_conv_clk;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

endmodule

// [adc_flag_sync.sv]
`timescale 1ns/1ps
module adc_flag_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_nrst,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Three stages; level accepted once stages two and three agree
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s1_q   <= '0;
      s2_q   <= '0;
      s3_q   <= '0;
      o_sync <= '0;
    end else if (i_en) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          o_sync[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// [adc_irq_mask_and_mode_regs.sv]
`timescale 1ns/1ps
// Function
// - enable register resets to zero
// - enable bits mirror low status flags
// - bit 6 gates accumulator threshold
// - bit 4 gates primary threshold
// - bit 3 gates primary overrange
// - bit 1 gates auxiliary result ready
// - bit 0 gates primary result ready
// - config register 8 bits, resets 0x03
// - bit 7 picks 512 or 131 kHz
// - low power enable ignored unless mode 01
// - mode 01 low power, else normal
module adc_irq_mask_and_mode_regs
  import adc_regs_pkg::*;
(
  input  wire logic                          i_clk_sys,
  input  wire logic                          i_nrst,
  input  wire logic                          i_ce,
  // AXI4-Lite slave
  input  wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [adc_regs_pkg::DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [adc_regs_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [adc_regs_pkg::DATA_W-1:0]    s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  // ADC side
  input  wire logic [adc_regs_pkg::REG_W-1:0] i_adc_status_flags,
  output logic                               o_adc_irq,
  output logic                               o_conversion_clock,
  output logic                               o_conv_clock_select,
  output adc_regs_pkg::power_ctrl_t          o_power_ctrl
);
  import adc_regs_pkg::*;

  logic [REG_W-1:0] irq_en_q;
  logic [REG_W-1:0] op_cfg_q;
  logic [REG_W-1:0] flags_s;
  logic [ADDR_W-1:0] awaddr_q;
  logic [DATA_W-1:0] wdata_q;
  logic [3:0]        wstrb_q;
  logic              aw_have_q;
  logic              w_have_q;
  logic              do_write;
  logic              conv_clk;
  power_ctrl_t       pwr_d;
  logic              irq_d;

  //////////////////////////////////////////////////////////////////////////////
  // Flags come from the converter logic, possibly another clock

  adc_flag_sync #(
    .W (REG_W)
  ) u_flag_sync (
    .i_clk_sys (i_clk_sys),
    .i_nrst    (i_nrst),
    .i_en      (i_ce),
    .i_async   (i_adc_status_flags),
    .o_sync    (flags_s)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data taken in either order

  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  // Address capture; awready drops once held
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_have_q     <= 1'b0;
      awaddr_q      <= '0;
      s_axi_awready <= 1'b1;
    end else if (i_ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (do_write) begin
        aw_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Data capture, same scheme
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      w_have_q     <= 1'b0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_wready <= 1'b1;
    end else if (i_ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (do_write) begin
        w_have_q     <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response; unmapped addresses get SLVERR
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (i_ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == IRQ_EN_ADDR || awaddr_q == OP_CFG_ADDR)
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers; only byte lane 0 carries data

  // Interrupt enable, reserved bits held at zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_en_q <= IRQ_EN_RESET;
    end else if (i_ce && do_write && awaddr_q == IRQ_EN_ADDR && wstrb_q[0]) begin
      irq_en_q <= wdata_q[REG_W-1:0] & IRQ_EN_MASK;
    end
  end

  // Operating config; reserved bit 6 kept zero
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      op_cfg_q <= OP_CFG_RESET;
    end else if (i_ce && do_write && awaddr_q == OP_CFG_ADDR && wstrb_q[0]) begin
      op_cfg_q <= wdata_q[REG_W-1:0] & OP_CFG_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel, one read in flight

  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (i_ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= RESP_OKAY;
        unique case (s_axi_araddr)
          IRQ_EN_ADDR: s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, irq_en_q};
          OP_CFG_ADDR: s_axi_rdata <= {{(DATA_W-REG_W){1'b0}}, op_cfg_q};
          default: begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt and power decode

  // Level interrupt, no latching: follows flags and enables
  always_comb begin
    irq_d = |(flags_s & irq_en_q);
  end

  // Low power only for code 01; bias enable only counts there
  always_comb begin
    pwr_d.low_power_mode = (op_cfg_q[PM_HI:PM_LO] == PM_LOW_POWER);
    pwr_d.low_power_bias = pwr_d.low_power_mode & op_cfg_q[BIT_LP_EN];
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      o_adc_irq           <= 1'b0;
      o_power_ctrl        <= '0;
      o_conv_clock_select <= OP_CFG_RESET[BIT_CLK_SEL];
      o_conversion_clock  <= 1'b0;
    end else if (i_ce) begin
      o_adc_irq           <= irq_d;
      o_power_ctrl        <= pwr_d;
      o_conv_clock_select <= op_cfg_q[BIT_CLK_SEL];
      o_conversion_clock  <= conv_clk;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Conversion clock from the system clock

  adc_conv_clk_gen u_conv_clk (
    .i_clk_sys  (i_clk_sys),
    .i_nrst     (i_nrst),
    .i_en       (i_ce),
    .i_fast     (op_cfg_q[BIT_CLK_SEL]),
    .o_conv_clk (conv_clk)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_en_reset;
    @(posedge i_clk_sys) $rose(i_nrst) |-> irq_en_q == IRQ_EN_RESET && op_cfg_q == OP_CFG_RESET;
  endproperty
  a_en_reset: assert property (p_en_reset) else $error("bad reset value");

  property p_irq_accum;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && flags_s[BIT_ACCUM_THR] && irq_en_q[BIT_ACCUM_THR] |=> o_adc_irq;
  endproperty
  a_irq_accum: assert property (p_irq_accum) else $error("accum irq missing");

  property p_irq_pthr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && flags_s[BIT_PRIMARY_THR] && irq_en_q[BIT_PRIMARY_THR] |=> o_adc_irq;
  endproperty
  a_irq_pthr: assert property (p_irq_pthr) else $error("threshold irq missing");

  property p_irq_ovr;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && flags_s[BIT_PRIMARY_OVR] && irq_en_q[BIT_PRIMARY_OVR] |=> o_adc_irq;
  endproperty
  a_irq_ovr: assert property (p_irq_ovr) else $error("overrange irq missing");

  property p_irq_aux;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && flags_s[BIT_AUX_RDY] && irq_en_q[BIT_AUX_RDY] |=> o_adc_irq;
  endproperty
  a_irq_aux: assert property (p_irq_aux) else $error("aux ready irq missing");

  property p_irq_prdy;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && flags_s[BIT_PRIMARY_RDY] && irq_en_q[BIT_PRIMARY_RDY] |=> o_adc_irq;
  endproperty
  a_irq_prdy: assert property (p_irq_prdy) else $error("primary rdy irq missing");

  property p_irq_quiet;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && ((flags_s & irq_en_q) == '0) |=> !o_adc_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious irq");

  property p_resv_zero;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      (irq_en_q & ~IRQ_EN_MASK) == '0 && (op_cfg_q & ~OP_CFG_MASK) == '0;
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit set");

  property p_lp_ignored;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && op_cfg_q[PM_HI:PM_LO] != PM_LOW_POWER |=> o_power_ctrl == '0;
  endproperty
  a_lp_ignored: assert property (p_lp_ignored) else $error("lp in normal mode");

  property p_lp_mode;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && op_cfg_q[PM_HI:PM_LO] == PM_LOW_POWER |=> o_power_ctrl.low_power_mode;
  endproperty
  a_lp_mode: assert property (p_lp_mode) else $error("low power not decoded");

  property p_clk_sel;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce |=> o_conv_clock_select == $past(op_cfg_q[BIT_CLK_SEL]);
  endproperty
  a_clk_sel: assert property (p_clk_sel) else $error("clock select mismatch");

  property p_write_cfg;
    @(posedge i_clk_sys) disable iff (!i_nrst)
      i_ce && do_write && awaddr_q == OP_CFG_ADDR && wstrb_q[0]
      |=> op_cfg_q == ($past(wdata_q[REG_W-1:0]) & OP_CFG_MASK);
  endproperty
  a_write_cfg: assert property (p_write_cfg) else $error("config write lost");

endmodule

// [adc_irq_mask_and_mode_regs_tb.sv]
`timescale 1ns/1ps
module adc_irq_mask_and_mode_regs_tb;
  import adc_regs_pkg::*;

  // Expected read answer, queued by the driver
  typedef struct {
    string       name;
    logic [31:0] data;
    logic [1:0]  resp;
  } note_t;

  logic        clk;
  logic        nrst;
  logic        ce;
  logic [31:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [31:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic [7:0]  flags;
  logic        irq;
  logic        conv_clk;
  logic        clk_sel;
  power_ctrl_t pwr;
  note_t       rd_q[$];
  logic [1:0]  wr_q[$];
  int          n_errors;
  int          num_checks;
  int          src[5] = '{0, 1, 3, 4, 6};

  adc_irq_mask_and_mode_regs i_adc_irq_mask_and_mode_regs (
    .i_clk_sys(clk), .i_nrst(nrst), .i_ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_adc_status_flags(flags), .o_adc_irq(irq), .o_conversion_clock(conv_clk),
    .o_conv_clock_select(clk_sel), .o_power_ctrl(pwr)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, 100 MHz
  initial clk = 1'b0;
  always #5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Write: both channels offered together, each dropped once taken
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    wr_q.push_back(er);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    // One edge apart, so a following call never re-raises it in the same step
    @(posedge clk);
  endtask

  task automatic axi_read(input string name, input logic [31:0] a, input logic [31:0] ed,
                          input logic [1:0] er);
    rd_q.push_back('{name, ed, er});
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    @(posedge clk);
  endtask

  // Half period counted in system cycles; two toggles first so a rate change settles
  task automatic measure(input string name, input int exp_half);
    int   n;
    logic v;
    n = 0;
    @(conv_clk);
    @(conv_clk);
    v = conv_clk;
    while (conv_clk === v) begin
      @(posedge clk);
      #1;
      n++;
    end
    check(name, n, exp_half);
    // Back on the edge, so the next drive lands there
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Monitor: every completed read takes the oldest note, every write response the oldest wr_q entry
  always @(posedge clk) begin
    note_t n;
    if (rvalid && rready) begin
      n = rd_q.pop_front();
      check(n.name, rdata, n.data);
      check("rresp", {30'h0, rresp}, {30'h0, n.resp});
    end
    if (bvalid && bready) begin
      check("bresp", {30'h0, bresp}, {30'h0, wr_q.pop_front()});
    end
  end

  // Watchdog, well beyond the slow clock measurements
  initial begin
    repeat (40000) @(posedge clk);
    n_errors++;
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] d;
    logic [7:0] f;
    logic [7:0] cfg;
    logic [2:0] k;
    logic       lp;
    n_errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    awaddr = 32'h0;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 32'h0;
    arvalid = 1'b0;
    rready = 1'b0;
    flags = 8'h00;
    void'($urandom(32'h7183));
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    // Reset values
    axi_read("en_reset", IRQ_EN_ADDR, 32'h0000_0000, RESP_OKAY);
    axi_read("cfg_reset", OP_CFG_ADDR, 32'h0000_0003, RESP_OKAY);
    check("sel_reset", {31'h0, clk_sel}, 32'h0);
    // Random enables; reserved bits read zero
    repeat (3) begin
      d = 8'($urandom);
      axi_write(IRQ_EN_ADDR, {24'h0, d}, 4'hf, RESP_OKAY);
      axi_read("en_rw", IRQ_EN_ADDR, {24'h0, d & 8'h5b}, RESP_OKAY);
    end
    // Lane disabled, then unmapped place: neither changes the register
    axi_write(IRQ_EN_ADDR, 32'h0000_00ff, 4'h0, RESP_OKAY);
    axi_write(32'hffff_0500, 32'h0000_00ff, 4'hf, RESP_SLVERR);
    axi_read("unmapped", 32'hffff_0500, 32'h0, RESP_SLVERR);
    axi_read("en_kept", IRQ_EN_ADDR, {24'h0, d & 8'h5b}, RESP_OKAY);
    // Each source: masked when others flag, passes its own, off when disabled
    foreach (src[i]) begin
      axi_write(IRQ_EN_ADDR, 32'h1 << src[i], 4'hf, RESP_OKAY);
      flags <= ~(8'h1 << src[i]);
      repeat (6) @(posedge clk);
      check("irq_masked", {31'h0, irq}, 32'h0);
      f = 8'($urandom) | (8'h1 << src[i]);
      flags <= f;
      repeat (6) @(posedge clk);
      check("irq_on", {31'h0, irq}, 32'h1);
      axi_write(IRQ_EN_ADDR, 32'h0, 4'hf, RESP_OKAY);
      repeat (2) @(posedge clk);
      check("irq_off", {31'h0, irq}, 32'h0);
    end
    // Clock enable low freezes the request level
    axi_write(IRQ_EN_ADDR, 32'h5b, 4'hf, RESP_OKAY);
    flags <= 8'h01;
    repeat (6) @(posedge clk);
    ce <= 1'b0;
    flags <= 8'h00;
    repeat (8) @(posedge clk);
    check("irq_frozen", {31'h0, irq}, 32'h1);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    check("irq_clear", {31'h0, irq}, 32'h0);
    // Every power mode, low power enable both ways except mode 01 where it is always set
    for (int i = 0; i < 8; i++) begin
      k = 3'(i);
      lp = (k[1:0] == 2'b01);
      // Slow clock and bias enable whenever low power is chosen
      cfg = {!lp, 1'b1, k[2] | lp, k[1:0], 3'b101};
      axi_write(OP_CFG_ADDR, {24'h0, cfg}, 4'hf, RESP_OKAY);
      axi_read("cfg_rw", OP_CFG_ADDR, {24'h0, cfg & 8'hbf}, RESP_OKAY);
      check("lp_mode", {31'h0, pwr.low_power_mode}, {31'h0, k[1:0] == 2'b01});
      check("lp_bias", {31'h0, pwr.low_power_bias}, {31'h0, lp});
      check("clk_sel", {31'h0, clk_sel}, {31'h0, cfg[7]});
    end
    // Conversion clock rates, half periods truncated
    axi_write(OP_CFG_ADDR, 32'h80, 4'hf, RESP_OKAY);
    measure("fast_half", 100_000_000 / (2 * 512_000));
    // Slow rate, here together with low power and its bias enable
    axi_write(OP_CFG_ADDR, 32'h28, 4'hf, RESP_OKAY);
    measure("slow_half", 100_000_000 / (2 * 131_000));
    repeat (4) @(posedge clk);
    conclude();
  end

endmodule

// [adc_regs_pkg.sv]
package adc_regs_pkg;

  // Bus and register geometry
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned REG_W     = 8;

  // Byte addresses of the two registers
  localparam logic [31:0] IRQ_EN_ADDR  = 32'hffff0504;
  localparam logic [31:0] OP_CFG_ADDR  = 32'hffff0508;

  // Reset values
  localparam logic [7:0]  IRQ_EN_RESET = 8'h00;
  localparam logic [7:0]  OP_CFG_RESET = 8'h03;

  // Writable bits of the enable register (7, 5 and 2 reserved)
  localparam logic [7:0]  IRQ_EN_MASK  = 8'h5b;

  // Enable and flag positions
  localparam int unsigned BIT_PRIMARY_RDY = 0;
  localparam int unsigned BIT_AUX_RDY     = 1;
  localparam int unsigned BIT_PRIMARY_OVR = 3;
  localparam int unsigned BIT_PRIMARY_THR = 4;
  localparam int unsigned BIT_ACCUM_THR   = 6;

  // Operating config field positions
  localparam int unsigned BIT_CLK_SEL     = 7;
  localparam int unsigned BIT_LP_EN       = 5;
  localparam int unsigned PM_HI           = 4;
  localparam int unsigned PM_LO           = 3;
  localparam logic [1:0]  PM_LOW_POWER    = 2'b01;

  // Reserved config bit reads as zero
  localparam logic [7:0]  OP_CFG_MASK     = 8'hbf;

  // Conversion clock rates
  localparam int unsigned CLK_SYS_HZ      = 100_000_000;
  localparam int unsigned CONV_FAST_HZ    = 512_000;
  localparam int unsigned CONV_SLOW_HZ    = 131_000;
  // Half-period counts, rounded down so the rate is never below the target
  localparam int unsigned FAST_HALF_CYC   = CLK_SYS_HZ / (2 * CONV_FAST_HZ);
  localparam int unsigned SLOW_HALF_CYC   = CLK_SYS_HZ / (2 * CONV_SLOW_HZ);
  localparam int unsigned DIV_W           = 10;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // Decoded power controls handed to the analog side
  typedef struct packed {
    logic low_power_mode;
    logic low_power_bias;
  } power_ctrl_t;

endpackage
